// file: acr_pkg.sv
/*
  Constants for the converter setup register bank: offsets, field positions,
  reset values and codes. Assumes a byte-wide register access port.
*/
package acr_pkg;
  localparam logic [7:0] ACR_OFS_CHSEL  = 8'h05;
  localparam logic [7:0] ACR_OFS_PWR    = 8'h08;
  localparam logic [7:0] ACR_OFS_GCLK   = 8'h09;
  localparam logic [7:0] ACR_OFS_CDIV   = 8'h0B;
  localparam logic [7:0] ACR_OFS_TEST   = 8'h0D;
  localparam logic [7:0] ACR_OFS_BIST   = 8'h0E;
  localparam logic [7:0] ACR_OFS_OFFS   = 8'h10;
  localparam logic [7:0] ACR_OFS_OMODE  = 8'h14;
  localparam logic [7:0] ACR_OFS_CPHASE = 8'h16;
  localparam logic [7:0] ACR_OFS_XFER   = 8'hFF;

  localparam logic [7:0] ACR_RST_CHSEL  = 8'h03;
  localparam logic [7:0] ACR_RST_GCLK   = 8'h01;
  localparam logic [7:0] ACR_RST_ZERO   = 8'h00;

  // Writable bit masks; open bits read zero
  localparam logic [7:0] ACR_MSK_CHSEL  = 8'h03;
  localparam logic [7:0] ACR_MSK_PWR    = 8'h23;
  localparam logic [7:0] ACR_MSK_GCLK   = 8'h01;
  localparam logic [7:0] ACR_MSK_CDIV   = 8'h07;
  localparam logic [7:0] ACR_MSK_TEST   = 8'h37;
  localparam logic [7:0] ACR_MSK_BIST   = 8'h05;
  localparam logic [7:0] ACR_MSK_OFFS   = 8'h3F;
  localparam logic [7:0] ACR_MSK_OMODE  = 8'hD7;
  localparam logic [7:0] ACR_MSK_CPHASE = 8'h87;

  localparam int ACR_BIT_PIN_STBY = 5;
  localparam int ACR_BIT_DCS      = 0;
  localparam int ACR_BIT_XFER     = 0;
  localparam int ACR_BIT_OE_N     = 4;
  localparam int ACR_BIT_INVERT   = 2;
  localparam int ACR_BIT_OTYPE    = 6;
  localparam int ACR_BIT_DRIVE    = 7;
  localparam int ACR_BIT_DCO_INV  = 7;
  localparam int ACR_BIT_RST_LONG = 5;
  localparam int ACR_BIT_RST_SHRT = 4;
  localparam int ACR_BIT_BIST_RST = 2;

  typedef enum logic [2:0] {
    ACR_TP_OFF    = 3'b000,
    ACR_TP_MID    = 3'b001,
    ACR_TP_POS_FS = 3'b010,
    ACR_TP_NEG_FS = 3'b011,
    ACR_TP_CHECK  = 3'b100,
    ACR_TP_LONG   = 3'b101,
    ACR_TP_SHORT  = 3'b110,
    ACR_TP_TOGGLE = 3'b111
  } acr_tp_e;

  typedef enum logic [1:0] {
    ACR_FMT_OBIN  = 2'b00,
    ACR_FMT_TWOS  = 2'b01,
    ACR_FMT_GRAY  = 2'b10,
    ACR_FMT_OBIN2 = 2'b11
  } acr_fmt_e;
endpackage

// file: acr_regs.sv
/*
  Setup register bank for a dual-channel converter. Host side is a simple
  byte port (write strobe, read strobe, address, data) on clk_sys; the active
  settings are shadows loaded by the transfer bit. Assumes the host port is
  synchronous to clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module acr_regs
  import acr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Host register port
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata,
  output logic             rvalid,
  // Global active settings
  output logic             pin_pdwn_is_stby,
  output logic             dcs_active,
  output logic      [2:0]  clk_div_code,
  output logic      [2:0]  clk_phase_delay,
  output logic             output_data_clock_invert,
  output logic             output_is_lvds,
  output logic             output_drive_low,
  // Per-channel active settings, index 0 is channel A
  output logic      [1:0]  pwr_mode [2],
  output logic      [2:0]  test_mode [2],
  output logic             long_prbs_sequence_reset [2],
  output logic             short_prbs_sequence_reset [2],
  output logic             self_test_control [2],
  output logic             bist_reset [2],
  output logic signed [5:0] offset_trim [2],
  output logic      [1:0]  out_format [2],
  output logic             out_invert [2],
  output logic             out_disable [2]
);
  logic [7:0] channel_select_r;
  // Master (host-written) copies
  logic [7:0] power_modes_r [2];
  logic [7:0] global_clock_config_r;
  logic [7:0] clock_divider_r;
  logic [7:0] test_pattern_select_r [2];
  logic [7:0] self_test_control_r [2];
  logic [7:0] offset_trim_r [2];
  logic [7:0] output_config_r [2];
  logic [7:0] clock_phase_config_r;
  logic       xfer_r;

  // Global registers ignore the channel bits
  logic wr_global;
  assign wr_global = wr_en;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      channel_select_r      <= ACR_RST_CHSEL;
      global_clock_config_r <= ACR_RST_GCLK;
      clock_divider_r       <= ACR_RST_ZERO;
      clock_phase_config_r  <= ACR_RST_ZERO;
    end else if (wr_global) begin
      case (addr)
        ACR_OFS_CHSEL:  channel_select_r      <= wdata & ACR_MSK_CHSEL;
        ACR_OFS_GCLK:   global_clock_config_r <= wdata & ACR_MSK_GCLK;
        ACR_OFS_CDIV:   clock_divider_r       <= wdata & ACR_MSK_CDIV;
        ACR_OFS_CPHASE: clock_phase_config_r  <= wdata & ACR_MSK_CPHASE;
        default: ;
      endcase
    end
  end

  // Transfer bit: set by write, cleared on the same edge that loads shadows
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      xfer_r <= 1'b0;
    end else if (wr_en && addr == ACR_OFS_XFER) begin
      xfer_r <= wdata[ACR_BIT_XFER];
    end else begin
      xfer_r <= 1'b0;
    end
  end

  // Per-channel master copies and shadows
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic sel;
      assign sel = wr_en && channel_select_r[ch];

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          power_modes_r[ch]         <= ACR_RST_ZERO;
          test_pattern_select_r[ch] <= ACR_RST_ZERO;
          self_test_control_r[ch]   <= ACR_RST_ZERO;
          offset_trim_r[ch]         <= ACR_RST_ZERO;
          output_config_r[ch]       <= ACR_RST_ZERO;
        end else if (sel) begin
          case (addr)
            ACR_OFS_PWR: begin
              power_modes_r[ch] <= wdata & ACR_MSK_PWR;
            end
            ACR_OFS_TEST:  test_pattern_select_r[ch] <= wdata & ACR_MSK_TEST;
            ACR_OFS_BIST:  self_test_control_r[ch]   <= wdata & ACR_MSK_BIST;
            ACR_OFS_OFFS:  offset_trim_r[ch]         <= wdata & ACR_MSK_OFFS;
            ACR_OFS_OMODE: output_config_r[ch]       <= wdata & ACR_MSK_OMODE;
            default: ;
          endcase
        end
      end

      // Shadows change only on transfer, both channels together
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          pwr_mode[ch]                  <= 2'b00;
          test_mode[ch]                 <= 3'b000;
          long_prbs_sequence_reset[ch]  <= 1'b0;
          short_prbs_sequence_reset[ch] <= 1'b0;
        end else if (xfer_r) begin
          pwr_mode[ch]                  <= power_modes_r[ch][1:0];
          test_mode[ch]                 <= test_pattern_select_r[ch][2:0];
          long_prbs_sequence_reset[ch]  <= test_pattern_select_r[ch][ACR_BIT_RST_LONG];
          short_prbs_sequence_reset[ch] <= test_pattern_select_r[ch][ACR_BIT_RST_SHRT];
        end
      end

      // Self-test shadows
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          self_test_control[ch]               <= 1'b0;
          bist_reset[ch]                <= 1'b0;
        end else if (xfer_r) begin
          self_test_control[ch]               <= self_test_control_r[ch][0];
          bist_reset[ch]                <= self_test_control_r[ch][ACR_BIT_BIST_RST];
        end
      end

      // Data coding shadows; trim and format act downstream of this block
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          offset_trim[ch]               <= 6'sd0;
          out_format[ch]                <= ACR_FMT_OBIN;
          out_invert[ch]                <= 1'b0;
          out_disable[ch]               <= 1'b0;
        end else if (xfer_r) begin
          offset_trim[ch]               <= $signed(offset_trim_r[ch][5:0]);
          out_format[ch]                <= output_config_r[ch][1:0];
          out_invert[ch]                <= output_config_r[ch][ACR_BIT_INVERT];
          out_disable[ch]               <= output_config_r[ch][ACR_BIT_OE_N];
        end
      end
    end
  endgenerate

  // Pin action is global; channel A copy holds it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_pdwn_is_stby <= 1'b0;
    end else if (xfer_r) begin
      pin_pdwn_is_stby <= power_modes_r[0][ACR_BIT_PIN_STBY];
    end
  end

  // Clock shadows; a divider other than one needs the stabilizer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dcs_active               <= 1'b1;
      clk_div_code             <= 3'b000;
      clk_phase_delay          <= 3'b000;
      output_data_clock_invert <= 1'b0;
    end else if (xfer_r) begin
      dcs_active               <= global_clock_config_r[ACR_BIT_DCS]
                                  | (clock_divider_r[2:0] != 3'b000);
      clk_div_code             <= clock_divider_r[2:0];
      clk_phase_delay          <= clock_phase_config_r[2:0];
      output_data_clock_invert <= clock_phase_config_r[ACR_BIT_DCO_INV];
    end
  end

  // Output driver shadows are global, held in the channel A copy
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      output_is_lvds   <= 1'b0;
      output_drive_low <= 1'b0;
    end else if (xfer_r) begin
      output_is_lvds   <= output_config_r[0][ACR_BIT_OTYPE];
      output_drive_low <= output_config_r[0][ACR_BIT_DRIVE];
    end
  end

  // Read path: local reads prefer channel A when both set
  // A read taken with a write in one cycle returns the old value
  logic rd_ch;
  assign rd_ch = ~channel_select_r[0] & channel_select_r[1];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd_en;
      if (rd_en) begin
        case (addr)
          ACR_OFS_CHSEL:  rdata <= channel_select_r;
          ACR_OFS_PWR:    rdata <= power_modes_r[rd_ch];
          ACR_OFS_GCLK:   rdata <= global_clock_config_r;
          ACR_OFS_CDIV:   rdata <= clock_divider_r;
          ACR_OFS_TEST:   rdata <= test_pattern_select_r[rd_ch];
          ACR_OFS_BIST:   rdata <= self_test_control_r[rd_ch];
          ACR_OFS_OFFS:   rdata <= offset_trim_r[rd_ch];
          ACR_OFS_OMODE:  rdata <= output_config_r[rd_ch];
          ACR_OFS_CPHASE: rdata <= clock_phase_config_r;
          ACR_OFS_XFER:   rdata <= {7'h00, xfer_r};
          default:        rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // acr_regs
`default_nettype wire

// file: acr_regs_monitor.sv
/* Checker for acr_regs settings and read port.
   Assumes binding to acr_regs, one clock, sync rst. */
`timescale 1ns/1ns
`default_nettype none
module acr_regs_monitor
  import acr_pkg::*;
(
  // Host port
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [7:0]        addr,
  input wire logic [7:0]        wdata,
  input wire logic [7:0]        rdata,
  input wire logic              rvalid,
  // Settings
  input wire logic              dcs_active,
  input wire logic [2:0]        clk_div_code,
  input wire logic [2:0]        test_mode [2],
  input wire logic signed [5:0] offset_trim [2]
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic xh;
  assign xh = wr_en && addr == ACR_OFS_XFER && wdata[ACR_BIT_XFER];
  a_div_forces_dcs: assert property (clk_div_code != 3'h0 |-> dcs_active)
    else $error("divider set with stabilizer off");
  a_div_held: assert property (!$past(xh, 2) && !$past(xh, 3) |-> $stable(clk_div_code))
    else $error("divider moved without transfer");
  a_test_held: assert property (!$past(xh, 2) && !$past(xh, 3) |-> $stable(test_mode[1]))
    else $error("test mode moved without transfer");
  a_trim_held: assert property (!$past(xh, 2) && !$past(xh, 3) |-> $stable(offset_trim[0]))
    else $error("trim moved without transfer");
  a_xfer_reads_one: assert property ($past(xh) && rd_en && addr == ACR_OFS_XFER |=> rdata == 8'h01)
    else $error("transfer bit not seen");
  a_rd_answer: assert property (rd_en |=> rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (rvalid |-> $past(rd_en))
    else $error("stray read answer");
  a_unmapped_zero: assert property (rd_en && addr == 8'h13 |=> rdata == 8'h00)
    else $error("open address not zero");
  c_xfer: cover property (xh);
  c_div_max: cover property (clk_div_code == 3'h7);
  c_xfer_rd: cover property (rd_en && addr == ACR_OFS_XFER);
endmodule // acr_regs_monitor
bind acr_regs acr_regs_monitor u_mon (.clk_sys, .rst, .wr_en, .rd_en, .addr, .wdata,
  .rdata, .rvalid, .dcs_active, .clk_div_code, .test_mode, .offset_trim);
`default_nettype wire

// file: acr_host.sv
/* Host model for the acr_regs byte port.
   Assumes the shared clk_sys; changes lines on falling edges. */
`timescale 1ns/1ns
`default_nettype none
module acr_host (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic       wr_en,
  output logic       rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 8'h00;
    wdata = 8'h00;
  end
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    wr_en <= w;
    rd_en <= r;
    // Released lines flip so no stale value looks valid
    addr  <= (w | r) ? a : ~addr;
    wdata <= w ? d : ~wdata;
  endtask
endmodule // acr_host
`default_nettype wire

// file: tb.sv
/* Testbench for acr_regs with queued read checks.
   Assumes acr_host drives the port and the checker is bound. */
`timescale 1ns/1ns
`default_nettype none
module tb;
  import acr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wr_en, rd_en, rvalid, dcs_active, pin_pdwn_is_stby;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] clk_div_code;
  logic [2:0] test_mode [2];
  logic signed [5:0] offset_trim [2];
  logic [1:0] out_format [2];
  logic [1:0] pmode [2];
  logic [2:0] phase;
  logic dco_inv, lvds, drv_low;
  logic prbs_l [2], prbs_s [2], bist_en [2], bist_rs [2], o_inv [2], o_dis [2];
  logic [7:0] tm, om, bs, pw, cp;
  logic [7:0] exp_q [$];
  logic [15:0] rst_tab [11] = '{16'h0503, 16'h0800, 16'h0901, 16'h0B00, 16'h0D00,
    16'h0E00, 16'h1000, 16'h1400, 16'h1600, 16'hFF00, 16'h1300};
  logic [5:0] ofs;
  int error_cnt = 0;
  int num_checks = 0;
  always #25 clk_sys = ~clk_sys;
  acr_regs i_acr_regs (.clk_sys, .rst, .wr_en, .rd_en, .addr, .wdata, .rdata, .rvalid,
    .pin_pdwn_is_stby, .dcs_active, .clk_div_code, .clk_phase_delay(phase),
    .output_data_clock_invert(dco_inv), .output_is_lvds(lvds), .output_drive_low(drv_low),
    .pwr_mode(pmode), .test_mode, .long_prbs_sequence_reset(prbs_l),
    .short_prbs_sequence_reset(prbs_s), .self_test_control(bist_en), .bist_reset(bist_rs),
    .offset_trim, .out_format, .out_invert(o_inv), .out_disable(o_dis));
  acr_host u_host (.clk_sys, .wr_en, .rd_en, .addr, .wdata);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.op(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.op(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic xfer();
    wr(ACR_OFS_XFER, 8'h01);
    rd(ACR_OFS_XFER, 8'h01);
    rd(ACR_OFS_XFER, 8'h00);
    u_host.op(1'b0, 1'b0, 8'h00, 8'h00);
    @(negedge clk_sys);
  endtask
  task automatic end_of_test();
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("unexpected at %0t: %0d reads never answered", $time, exp_q.size());
    end
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Falling edge keeps clear of the launch edge of rvalid
  always @(negedge clk_sys) begin
    if (rvalid === 1'b1 && exp_q.size() > 0) begin
      chk(rdata, exp_q.pop_front());
    end else if (rvalid !== 1'b0 && rst === 1'b0) begin
      error_cnt++;
      $display("unexpected at %0t: read answer with nothing queued", $time);
    end
  end
  initial begin
    #(50 * 5000);
    error_cnt++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'hD076FCDD));
    repeat (4) @(negedge clk_sys);
    rst <= 1'b0;
    foreach (rst_tab[k])
      rd(rst_tab[k][15:8], rst_tab[k][7:0]);
    chk({7'h0, dcs_active}, 8'h01);
    $display("reset values done");
    wr(ACR_OFS_CHSEL, 8'h01);
    wr(ACR_OFS_TEST, 8'h05);
    wr(ACR_OFS_CHSEL, 8'h02);
    wr(ACR_OFS_TEST, 8'h06);
    rd(ACR_OFS_TEST, 8'h06);
    wr(ACR_OFS_CHSEL, 8'h03);
    rd(ACR_OFS_TEST, 8'h05);
    chk({5'h0, test_mode[0]}, 8'h00);
    xfer();
    chk({5'h0, test_mode[0]}, 8'h05);
    chk({5'h0, test_mode[1]}, 8'h06);
    $display("channel steering done");
    for (int i = 0; i < 8; i++) begin
      ofs = (i == 0) ? 6'h1F : (i == 1) ? 6'h20 : 6'($urandom);
      tm = (8'($urandom) & 8'h30) | 8'(i);
      om = (8'($urandom) & 8'hD4) | 8'(i & 3);
      bs = 8'($urandom) & ACR_MSK_BIST;
      pw = (8'($urandom) & 8'h03) | 8'((i & 1) << 5);
      cp = 8'($urandom) & ACR_MSK_CPHASE;
      wr(ACR_OFS_GCLK, 8'h00);
      wr(ACR_OFS_CDIV, 8'(i));
      wr(ACR_OFS_TEST, tm);
      wr(ACR_OFS_OMODE, om);
      wr(ACR_OFS_PWR, pw);
      wr(ACR_OFS_OFFS, {2'b00, ofs});
      wr(ACR_OFS_BIST, bs);
      wr(ACR_OFS_CPHASE, cp);
      rd(ACR_OFS_OMODE, om);
      chk({5'h0, clk_div_code}, 8'(i == 0 ? 0 : i - 1));
      xfer();
      chk({5'h0, clk_div_code}, 8'(i));
      chk({7'h0, dcs_active}, {7'h0, i != 0});
      chk({5'h0, test_mode[1]}, 8'(i));
      chk({6'h0, out_format[0]}, 8'(i & 3));
      chk({7'h0, pin_pdwn_is_stby}, 8'(i & 1));
      chk({6'h0, prbs_l[0], prbs_s[1]}, {6'h0, tm[5:4]});
      chk({4'h0, drv_low, lvds, o_dis[1], o_inv[0]}, {4'h0, om[7:6], om[4], om[2]});
      chk({6'h0, pmode[1]}, pw & 8'h03);
      chk({6'h0, bist_rs[0], bist_en[1]}, {6'h0, bs[2], bs[0]});
      chk({4'h0, dco_inv, phase}, {4'h0, cp[7], cp[2:0]});
      chk({2'h0, offset_trim[0]}, {2'h0, ofs});
      chk({2'h0, offset_trim[1]}, {2'h0, ofs});
    end
    $display("settings sweep done");
    end_of_test();
  end
endmodule // tb
`default_nettype wire
